// ### src/mpp_pkg.sv
// constants for the post-processing register bank
package mpp_pkg;
  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam int ADDR_W = 9;
  localparam logic [8:0] A_CORR_EN = 9'h133;
  localparam logic [8:0] A_DEMAP = 9'h134;
  localparam logic [8:0] A_THR_LO = 9'h135;
  localparam logic [8:0] A_THR_HI = 9'h136;
  localparam logic [8:0] A_NORM = 9'h137;
  localparam logic [8:0] A_GAIN = 9'h138;
  localparam logic [8:0] A_SCALE_OVF = 9'h139;
  localparam logic [8:0] A_RANGE_OVF = 9'h13B;
  localparam logic [8:0] A_CARR_LO = 9'h13C;
  localparam logic [8:0] A_CARR_HI = 9'h13D;
  localparam logic [8:0] A_PH_RE = 9'h13E;
  localparam logic [8:0] A_PH_IM = 9'h13F;
  localparam logic [8:0] A_PS_FRAMES = 9'h140;
  localparam logic [8:0] A_PS_MISS = 9'h141;
  localparam logic [8:0] A_RUN_LO = 9'h142;
  localparam logic [8:0] A_RUN_HI = 9'h143;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic RST_CORR_EN = 1'b1;
  localparam logic [7:0] RST_DEMAP = 8'hE0;
  localparam logic [7:0] RST_THR_LO = 8'h00;
  localparam logic [5:0] RST_THR_HI = 6'h06;
  localparam logic [3:0] RST_NORM = 4'hB;
  localparam logic [7:0] RST_GAIN = 8'h80;
  // ************************************************************
  // demap control bit positions
  // ************************************************************
  localparam int NEG_RR = 7;
  localparam int NEG_IR = 6;
  localparam int NEG_RI = 5;
  localparam int NEG_II = 4;
  localparam int ZER_RR = 3;
  localparam int ZER_IR = 2;
  localparam int ZER_RI = 1;
  localparam int ZER_II = 0;
  // ************************************************************
  // datapath widths and limits
  // ************************************************************
  localparam int FFT_W = 12;
  localparam int PRE_W = 12;
  localparam int MET_W = 13;
  localparam int PH_W = 8;
  localparam int GAIN_FRAC = 7;
  localparam int CARR_W = 10;
  localparam logic [4:0] SCALE_MAX = 5'h0F;
endpackage : mpp_pkg

// ### src/mpp_demap_if.sv
// carrier and control bundle between post processing and demapper
`timescale 1ns/10ps
interface mpp_demap_if;
  logic [7:0] ctrl;
  logic in_valid;
  logic signed [mpp_pkg::PRE_W-1:0] in_re;
  logic signed [mpp_pkg::PRE_W-1:0] in_im;
  logic out_valid;
  logic signed [mpp_pkg::MET_W-1:0] out_re;
  logic signed [mpp_pkg::MET_W-1:0] out_im;
  modport src (output ctrl, in_valid, in_re, in_im,
               input out_valid, out_re, out_im);
  modport demap (input ctrl, in_valid, in_re, in_im,
                 output out_valid, out_re, out_im);
endinterface : mpp_demap_if

// ### src/mpp_demap.sv
// soft metric demapper: cross-adds re and im with sign and zero control
`timescale 1ns/10ps
module mpp_demap (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  mpp_demap_if.demap dif // carrier in, metric out
);
  localparam int W = mpp_pkg::MET_W;

  logic signed [W-1:0] t_rr, t_ir, t_ri, t_ii;
  logic signed [W-1:0] re_x, im_x;
  logic [7:0] c;

  // ************************************************************
  // contribution terms
  // ************************************************************
  always_comb begin
    c = dif.ctrl;
    re_x = W'(dif.in_re);
    im_x = W'(dif.in_im);
    t_rr = c[mpp_pkg::ZER_RR] ? '0
           : (c[mpp_pkg::NEG_RR] ? -re_x : re_x);
    t_ir = c[mpp_pkg::ZER_IR] ? '0
           : (c[mpp_pkg::NEG_IR] ? -im_x : im_x);
    t_ri = c[mpp_pkg::ZER_RI] ? '0
           : (c[mpp_pkg::NEG_RI] ? -re_x : re_x);
    t_ii = c[mpp_pkg::ZER_II] ? '0
           : (c[mpp_pkg::NEG_II] ? -im_x : im_x);
  end

  // 13-bit result holds any sum of two 12-bit terms
  always_ff @(posedge clk) begin
    if (rst) begin
      dif.out_re <= '0;
      dif.out_im <= '0;
    end else if (dif.in_valid) begin
      dif.out_re <= t_rr + t_ir;
      dif.out_im <= t_ri + t_ii;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dif.out_valid <= 1'b0;
    end else begin
      dif.out_valid <= dif.in_valid;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  demap_sum_a: assert property (@(posedge clk) disable iff (rst)
    dif.in_valid && dif.ctrl == 8'h00 |=>
    dif.out_re == $past(W'(dif.in_re)) + $past(W'(dif.in_im)))
    else $error("demap plain sum wrong");
  demap_zero_a: assert property (@(posedge clk) disable iff (rst)
    dif.in_valid && dif.ctrl[3:0] == 4'hF |=>
    dif.out_re == '0 && dif.out_im == '0)
    else $error("demap zero force ignored");
  demap_neg_a: assert property (@(posedge clk) disable iff (rst)
    dif.in_valid && dif.ctrl == 8'hA4 |=>
    dif.out_re == -$past(W'(dif.in_re))
    && dif.out_im == -$past(W'(dif.in_re)) + $past(W'(dif.in_im)))
    else $error("demap sign control wrong");
endmodule : mpp_demap

// ### src/mpp_regs.sv
// post-FFT scaling, phase correction, demap and frame counter registers
`timescale 1ns/10ps
// What this block does
// - correction runs when enable is one, bypassed at zero; resets to one
// - each soft metric sums contributions from real and imaginary inputs
// - demap bits 7..4 negate rr, ir, ri, ii contributions
// - demap bits 3..0 force the same contributions to zero
// - correction uses only carriers whose real part meets the threshold
// - threshold is relative to full scale, 0FFF meaning 2047/2048
// - FFT output scaled by two to the normalization exponent
// - FFT output multiplied by gain over 128, reset unity
// - 8-bit counter of overall scaling overflow events, resets zero
// - 8-bit counter of preprocessing range overflows, resets zero
// - per symbol, 10-bit count of carriers used for the phasor
// - phasor real and imaginary readable as 8-bit two's complement
// - 4-bit count of frames while in pre-sync
// - 3-bit count of frames without marker detection
// - 16-bit run of missed markers in sync, cleared on detection
module mpp_regs (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rst, // synchronous reset, high
  input wire logic [8:0] reg_addr, // register byte address
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, one cycle after strobe
  input wire logic fft_valid, // carrier from FFT valid
  input wire logic fft_last, // last carrier of symbol
  input wire logic signed [11:0] fft_re, // FFT mantissa real
  input wire logic signed [11:0] fft_im, // FFT mantissa imaginary
  input wire logic [3:0] fft_exp, // FFT block shift
  input wire logic phasor_load, // new phasor from estimator
  input wire logic signed [7:0] phasor_re_in, // estimated phasor real
  input wire logic signed [7:0] phasor_im_in, // estimated phasor imag
  input wire logic frame_tick, // one frame received
  input wire logic presync, // frame sync in pre-sync state
  input wire logic in_sync, // frame sync in sync state
  input wire logic marker_found, // marker symbol detected this frame
  output logic met_valid, // soft metric valid
  output logic signed [12:0] met_re, // real soft metric
  output logic signed [12:0] met_im // imaginary soft metric
);
  localparam int PW = mpp_pkg::PRE_W;
  localparam int SW = mpp_pkg::FFT_W + 16;
  localparam int MW = SW + 9;

  // ************************************************************
  // software registers
  // ************************************************************
  logic corr_en_q;
  logic [7:0] demap_q;
  logic [7:0] thr_lo_q;
  logic [5:0] thr_hi_q;
  logic [3:0] norm_q;
  logic [7:0] gain_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      corr_en_q <= mpp_pkg::RST_CORR_EN;
      demap_q <= mpp_pkg::RST_DEMAP;
      thr_lo_q <= mpp_pkg::RST_THR_LO;
      thr_hi_q <= mpp_pkg::RST_THR_HI;
      norm_q <= mpp_pkg::RST_NORM;
      gain_q <= mpp_pkg::RST_GAIN;
    end else if (reg_wr) begin
      case (reg_addr)
        mpp_pkg::A_CORR_EN: corr_en_q <= reg_wdata[0];
        mpp_pkg::A_DEMAP: demap_q <= reg_wdata;
        mpp_pkg::A_THR_LO: thr_lo_q <= reg_wdata;
        mpp_pkg::A_THR_HI: thr_hi_q <= reg_wdata[5:0];
        mpp_pkg::A_NORM: norm_q <= reg_wdata[3:0];
        mpp_pkg::A_GAIN: gain_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // stage 1: exponent shift, linear gain, range limit
  // ************************************************************
  logic signed [SW-1:0] sh_re, sh_im;
  logic signed [MW-1:0] g_re, g_im;
  logic signed [MW-1:0] lim_hi, lim_lo;
  logic ovf_re, ovf_im, scale_ovf;
  logic s1_valid_q, s1_last_q;
  logic signed [PW-1:0] s1_re_q, s1_im_q;

  always_comb begin
    sh_re = SW'(fft_re) <<< norm_q;
    sh_im = SW'(fft_im) <<< norm_q;
    g_re = (MW'(sh_re) * $signed({1'b0, gain_q}))
           >>> mpp_pkg::GAIN_FRAC;
    g_im = (MW'(sh_im) * $signed({1'b0, gain_q}))
           >>> mpp_pkg::GAIN_FRAC;
    lim_hi = MW'((1 <<< (PW - 1)) - 1);
    lim_lo = -MW'(1 <<< (PW - 1));
    ovf_re = (g_re > lim_hi) || (g_re < lim_lo);
    ovf_im = (g_im > lim_hi) || (g_im < lim_lo);
    // fft shift plus norm shift beyond what the datapath can carry
    scale_ovf = ({1'b0, fft_exp} + {1'b0, norm_q}) > mpp_pkg::SCALE_MAX;
  end

  // clipping keeps a single overflow from wrapping the metric sign
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_re_q <= '0;
      s1_im_q <= '0;
    end else if (fft_valid) begin
      s1_re_q <= ovf_re ? (g_re[MW-1] ? lim_lo[PW-1:0] : lim_hi[PW-1:0])
                        : g_re[PW-1:0];
      s1_im_q <= ovf_im ? (g_im[MW-1] ? lim_lo[PW-1:0] : lim_hi[PW-1:0])
                        : g_im[PW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_valid_q <= 1'b0;
      s1_last_q <= 1'b0;
    end else begin
      s1_valid_q <= fft_valid;
      s1_last_q <= fft_valid && fft_last;
    end
  end

  // ************************************************************
  // overflow event counters
  // ************************************************************
  logic [7:0] scale_ovf_q, range_ovf_q;
  logic range_ev;
  assign range_ev = fft_valid && (ovf_re || ovf_im);

  always_ff @(posedge clk) begin
    if (rst) begin
      scale_ovf_q <= 8'h00;
    end else if (fft_valid && scale_ovf && scale_ovf_q != 8'hFF) begin
      scale_ovf_q <= scale_ovf_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      range_ovf_q <= 8'h00;
    end else if (range_ev && range_ovf_q != 8'hFF) begin
      range_ovf_q <= range_ovf_q + 8'h01;
    end
  end

  // ************************************************************
  // phase offset correction
  // ************************************************************
  logic signed [PW-1:0] thr_cmp;
  logic use_carr;
  logic [9:0] carr_run_q, carr_q;
  logic signed [7:0] ph_re_q, ph_im_q;
  logic signed [PW+9:0] rot_re, rot_im;
  logic signed [PW-1:0] s2_re_q, s2_im_q;
  logic s2_valid_q;

  // bit 0 of the 14-bit field sits below the 2048-step carrier grid
  // field bit 13 is kept zero by software and not compared
  assign thr_cmp = $signed({thr_hi_q[4:0], thr_lo_q[7:1]});
  assign use_carr = s1_valid_q && (s1_re_q >= thr_cmp);

  always_ff @(posedge clk) begin
    if (rst) begin
      carr_run_q <= '0;
    end else if (s1_last_q) begin
      carr_run_q <= '0;
    end else if (use_carr && carr_run_q != 10'h3FF) begin
      carr_run_q <= carr_run_q + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      carr_q <= '0;
    end else if (s1_last_q) begin
      carr_q <= (use_carr && carr_run_q != 10'h3FF) ?
                carr_run_q + 10'h001 : carr_run_q;
    end
  end

  // unity phasor until the estimator supplies one
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_re_q <= 8'h7F;
      ph_im_q <= 8'h00;
    end else if (phasor_load) begin
      ph_re_q <= phasor_re_in;
      ph_im_q <= phasor_im_in;
    end
  end

  // multiply by the conjugate phasor, 2^-7 weighting
  always_comb begin
    rot_re = (PW'(s1_re_q) * ph_re_q + PW'(s1_im_q) * ph_im_q)
             >>> mpp_pkg::GAIN_FRAC;
    rot_im = (PW'(s1_im_q) * ph_re_q - PW'(s1_re_q) * ph_im_q)
             >>> mpp_pkg::GAIN_FRAC;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s2_re_q <= '0;
      s2_im_q <= '0;
    end else if (s1_valid_q) begin
      s2_re_q <= corr_en_q ? rot_re[PW-1:0] : s1_re_q;
      s2_im_q <= corr_en_q ? rot_im[PW-1:0] : s1_im_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s2_valid_q <= 1'b0;
    end else begin
      s2_valid_q <= s1_valid_q;
    end
  end

  // ************************************************************
  // demapper
  // ************************************************************
  mpp_demap_if dif ();
  assign dif.ctrl = demap_q;
  assign dif.in_valid = s2_valid_q;
  assign dif.in_re = s2_re_q;
  assign dif.in_im = s2_im_q;
  assign met_valid = dif.out_valid;
  assign met_re = dif.out_re;
  assign met_im = dif.out_im;

  mpp_demap u_demap (
    .clk (clk),
    .rst (rst),
    .dif (dif)
  );

  // ************************************************************
  // frame counters
  // ************************************************************
  logic [3:0] ps_frames_q;
  logic [2:0] ps_miss_q;
  logic [15:0] run_q;
  logic presync_q;
  logic ps_enter;
  assign ps_enter = presync && !presync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      presync_q <= 1'b0;
    end else begin
      presync_q <= presync;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ps_frames_q <= '0;
    end else if (ps_enter) begin
      // a frame on the entry cycle still counts
      ps_frames_q <= {3'h0, frame_tick};
    end else if (presync && frame_tick && ps_frames_q != 4'hF) begin
      ps_frames_q <= ps_frames_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ps_miss_q <= '0;
    end else if (ps_enter) begin
      ps_miss_q <= {2'h0, frame_tick && !marker_found};
    end else if (presync && frame_tick && !marker_found
                 && ps_miss_q != 3'h7) begin
      ps_miss_q <= ps_miss_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= '0;
    end else if (in_sync && frame_tick) begin
      if (marker_found) begin
        run_q <= '0;
      end else if (run_q != 16'hFFFF) begin
        run_q <= run_q + 16'h0001;
      end
    end
  end

  // ************************************************************
  // read path with high-byte snapshot
  // ************************************************************
  logic [1:0] carr_snap_q;
  logic [7:0] run_snap_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      carr_snap_q <= '0;
      run_snap_q <= '0;
    end else if (reg_rd) begin
      if (reg_addr == mpp_pkg::A_CARR_LO) begin
        carr_snap_q <= carr_q[9:8];
      end
      if (reg_addr == mpp_pkg::A_RUN_LO) begin
        run_snap_q <= run_q[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        mpp_pkg::A_CORR_EN: reg_rdata <= {7'h00, corr_en_q};
        mpp_pkg::A_DEMAP: reg_rdata <= demap_q;
        mpp_pkg::A_THR_LO: reg_rdata <= thr_lo_q;
        mpp_pkg::A_THR_HI: reg_rdata <= {2'h0, thr_hi_q};
        mpp_pkg::A_NORM: reg_rdata <= {4'h0, norm_q};
        mpp_pkg::A_GAIN: reg_rdata <= gain_q;
        mpp_pkg::A_SCALE_OVF: reg_rdata <= scale_ovf_q;
        mpp_pkg::A_RANGE_OVF: reg_rdata <= range_ovf_q;
        mpp_pkg::A_CARR_LO: reg_rdata <= carr_q[7:0];
        mpp_pkg::A_CARR_HI: reg_rdata <= {6'h00, carr_snap_q};
        mpp_pkg::A_PH_RE: reg_rdata <= ph_re_q;
        mpp_pkg::A_PH_IM: reg_rdata <= ph_im_q;
        mpp_pkg::A_PS_FRAMES: reg_rdata <= {4'h0, ps_frames_q};
        mpp_pkg::A_PS_MISS: reg_rdata <= {5'h00, ps_miss_q};
        mpp_pkg::A_RUN_LO: reg_rdata <= run_q[7:0];
        mpp_pkg::A_RUN_HI: reg_rdata <= run_snap_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence frame_miss_s;
    in_sync && frame_tick && !marker_found;
  endsequence
  sequence frame_hit_s;
    in_sync && frame_tick && marker_found;
  endsequence

  run_clear_a: assert property (@(posedge clk) disable iff (rst)
    frame_hit_s |=> run_q == 16'h0000)
    else $error("miss run not cleared");
  run_count_a: assert property (@(posedge clk) disable iff (rst)
    frame_miss_s ##0 run_q == 16'h0000 |=> run_q == 16'h0001)
    else $error("miss run not counting");
  corr_bypass_a: assert property (@(posedge clk) disable iff (rst)
    s1_valid_q && !corr_en_q |=> s2_re_q == $past(s1_re_q)
    && s2_im_q == $past(s1_im_q))
    else $error("bypass altered carrier");
  scale_cnt_a: assert property (@(posedge clk) disable iff (rst)
    fft_valid && scale_ovf |=> scale_ovf_q ==
    ($past(scale_ovf_q) == 8'hFF ? 8'hFF : $past(scale_ovf_q) + 8'h01))
    else $error("scaling overflow not counted");
  range_sat_a: assert property (@(posedge clk) disable iff (rst)
    range_ovf_q == 8'hFF |=> range_ovf_q == 8'hFF)
    else $error("range counter wrapped");
  range_cnt_a: assert property (@(posedge clk) disable iff (rst)
    !range_ev |=> range_ovf_q == $past(range_ovf_q))
    else $error("range counter moved without event");
  carr_snap_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == mpp_pkg::A_CARR_LO ##2
    reg_rd && reg_addr == mpp_pkg::A_CARR_HI |=>
    reg_rdata == {6'h00, $past(carr_q[9:8], 3)})
    else $error("carrier high byte not coherent");
  ps_frame_a: assert property (@(posedge clk) disable iff (rst)
    !presync |=> ps_frames_q == $past(ps_frames_q))
    else $error("pre-sync counter moved outside pre-sync");
  gain_unity_a: assert property (@(posedge clk) disable iff (rst)
    fft_valid && gain_q == 8'h80 && norm_q == 4'h0 |=> s1_re_q == $past(fft_re))
    else $error("unity gain altered data");
endmodule : mpp_regs

// ### test/mpp_fft_model.sv
// upstream carrier source and downstream metric sink model
`timescale 1ns/10ps
module mpp_fft_model (
  input wire logic clk, // system clock
  output logic fft_valid, // carrier valid
  output logic fft_last, // last carrier of symbol
  output logic signed [11:0] fft_re, // mantissa real
  output logic signed [11:0] fft_im, // mantissa imaginary
  output logic [3:0] fft_exp, // block shift
  input wire logic met_valid, // metric valid
  input wire logic signed [12:0] met_re, // metric real
  input wire logic signed [12:0] met_im // metric imaginary
);
  logic signed [12:0] got_re;
  logic signed [12:0] got_im;
  initial begin
    fft_valid = 1'h0;
    fft_last = 1'h0;
    fft_re = 12'h000;
    fft_im = 12'h000;
    fft_exp = 4'h0;
    got_re = 13'h0000;
    got_im = 13'h0000;
  end
  task automatic send(input logic [11:0] re, im, input logic [3:0] ex,
                      input logic last);
    @(posedge clk);
    fft_valid <= 1'h1;
    fft_last <= last;
    fft_re <= re;
    fft_im <= im;
    fft_exp <= ex;
    @(posedge clk);
    fft_valid <= 1'h0;
    fft_last <= 1'h0;
    // idle lines carry the inverse so stale data never looks live
    fft_re <= ~re;
    fft_im <= ~im;
    fft_exp <= ~ex;
  endtask : send
  always @(posedge clk) begin
    if (met_valid) begin
      got_re <= met_re;
      got_im <= met_im;
    end
  end
endmodule : mpp_fft_model

// ### test/test_mpp_regs.sv
// self-checking bench for the post-processing register bank
`timescale 1ns/10ps
module test_mpp_regs;
  logic clk, rst, reg_wr, reg_rd, fft_valid, fft_last, met_valid;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, c;
  logic signed [11:0] fft_re, fft_im;
  logic [3:0] fft_exp;
  logic phasor_load, frame_tick, presync, in_sync, marker_found;
  logic signed [7:0] phasor_re_in, phasor_im_in;
  logic signed [12:0] met_re, met_im;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [16:0] rv [16] = '{17'h13301, 17'h134E0, 17'h13500, 17'h13606,
    17'h1370B, 17'h13880, 17'h13900, 17'h13B00, 17'h13E7F, 17'h13F00,
    17'h14000, 17'h14100, 17'h14200, 17'h14300, 17'h13A00, 17'h00000};
  logic [24:0] wv [7] = '{25'h133FF01, 25'h1361F1F, 25'h137FF0F,
    25'h1395500, 25'h134A5A5, 25'h1353C3C, 25'h13E127F};
  logic [39:0] sc [6] = '{40'h0801000100, 40'h0401000080, 40'h1801000200,
    40'h0FF10001FE, 40'h2C00110066, 40'h48010007FF};
  logic [7:0] dc [4] = '{8'hE0, 8'h00, 8'h0F, 8'hA4};
  mpp_regs uut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .fft_valid, .fft_last, .fft_re, .fft_im, .fft_exp,
    .phasor_load, .phasor_re_in, .phasor_im_in, .frame_tick, .presync,
    .in_sync, .marker_found, .met_valid, .met_re, .met_im);
  mpp_fft_model src (.clk, .fft_valid, .fft_last, .fft_re, .fft_im,
    .fft_exp, .met_valid, .met_re, .met_im);
  // **********
  // helpers
  // **********
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rdc(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, e});
  endtask : rdc
  task automatic car(input logic [11:0] a, b, input logic [12:0] er, ei);
    src.send(a, b, 4'h0, 1'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("met_valid", {15'h0000, met_valid}, 16'h0001);
    @(posedge clk);
    #1;
    chk("met_re", {3'h0, src.got_re}, {3'h0, er});
    chk("met_im", {3'h0, src.got_im}, {3'h0, ei});
  endtask : car
  task automatic tick(input logic m);
    @(posedge clk);
    frame_tick <= 1'h1;
    marker_found <= m;
    @(posedge clk);
    frame_tick <= 1'h0;
  endtask : tick
  function automatic logic [12:0] dm(logic [7:0] k,
      logic signed [11:0] a, b, int o);
    logic signed [12:0] x;
    logic signed [12:0] y;
    x = {a[11], a};
    y = {b[11], b};
    if (k[7-2*o]) x = -x;
    if (k[6-2*o]) y = -y;
    if (k[3-2*o]) x = 13'h0000;
    if (k[2-2*o]) y = 13'h0000;
    return x + y;
  endfunction : dm
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // **********
  // clock, watchdog and tests
  // **********
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // run needs about 1900 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'h1;
    reg_addr = 9'h000;
    reg_wr = 1'h0;
    reg_wdata = 8'h00;
    reg_rd = 1'h0;
    phasor_load = 1'h0;
    phasor_re_in = 8'h00;
    phasor_im_in = 8'h00;
    frame_tick = 1'h0;
    presync = 1'h0;
    in_sync = 1'h0;
    marker_found = 1'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    foreach (rv[i]) begin
      rdc(rv[i][16:8], rv[i][7:0]);
    end
    $display("reset values done");
    foreach (wv[i]) begin
      wr(wv[i][24:16], wv[i][15:8]);
      rdc(wv[i][24:16], wv[i][7:0]);
    end
    $display("write readback done");
    wr(9'h133, 8'h00);
    wr(9'h137, 8'h00);
    wr(9'h138, 8'h80);
    for (int i = 0; i < 12; i++) begin
      c = i < 8 ? 8'h01 << i : dc[i-8];
      wr(9'h134, c);
      car(12'h123, 12'hD0B, dm(c, 12'h123, 12'hD0B, 0),
          dm(c, 12'h123, 12'hD0B, 1));
    end
    $display("demap done");
    wr(9'h134, 8'h05);
    foreach (sc[i]) begin
      wr(9'h137, {4'h0, sc[i][39:36]});
      wr(9'h138, sc[i][35:28]);
      car(sc[i][27:16], 12'h000, sc[i][12:0],
          sc[i][12:0]);
    end
    rdc(9'h13B, 8'h01);
    $display("scaling done");
    wr(9'h137, 8'h0B);
    src.send(12'h000, 12'h000, 4'h4, 1'h0);
    repeat (3) @(posedge clk);
    rdc(9'h139, 8'h00);
    // full-scale carriers drive both counters past saturation
    repeat (260) src.send(12'h7FF, 12'h000, 4'h5, 1'h0);
    repeat (4) @(posedge clk);
    rdc(9'h139, 8'hFF);
    rdc(9'h13B, 8'hFF);
    $display("overflow counters done");
    wr(9'h133, 8'h01);
    wr(9'h137, 8'h00);
    car(12'h100, 12'h000, 13'h00FE, 13'h00FE);
    wr(9'h135, 8'h00);
    wr(9'h136, 8'h02);
    // close the symbol left open by earlier carriers, below threshold
    src.send(12'hF00, 12'h000, 4'h0, 1'h1);
    src.send(12'h100, 12'h000, 4'h0, 1'h0);
    src.send(12'h0FF, 12'h000, 4'h0, 1'h0);
    src.send(12'h7FF, 12'h000, 4'h0, 1'h0);
    src.send(12'hF00, 12'h000, 4'h0, 1'h0);
    src.send(12'h100, 12'h000, 4'h0, 1'h1);
    repeat (3) @(posedge clk);
    rdc(9'h13C, 8'h03);
    rdc(9'h13D, 8'h00);
    @(posedge clk);
    phasor_load <= 1'h1;
    phasor_re_in <= 8'h40;
    phasor_im_in <= 8'hC0;
    @(posedge clk);
    phasor_load <= 1'h0;
    rdc(9'h13E, 8'h40);
    rdc(9'h13F, 8'hC0);
    car(12'h100, 12'h000, 13'h0080, 13'h0080);
    $display("phase correction done");
    @(posedge clk);
    presync <= 1'h1;
    tick(1'h1);
    tick(1'h1);
    tick(1'h0);
    rdc(9'h140, 8'h03);
    rdc(9'h141, 8'h01);
    repeat (20) tick(1'h0);
    rdc(9'h140, 8'h0F);
    rdc(9'h141, 8'h07);
    @(posedge clk);
    presync <= 1'h0;
    in_sync <= 1'h1;
    repeat (3) tick(1'h0);
    rdc(9'h142, 8'h03);
    rdc(9'h143, 8'h00);
    tick(1'h1);
    rdc(9'h142, 8'h00);
    repeat (300) tick(1'h0);
    rdc(9'h142, 8'h2C);
    rdc(9'h143, 8'h01);
    // high byte stays the snapshot until the low byte is read again
    repeat (212) tick(1'h0);
    rdc(9'h143, 8'h01);
    rdc(9'h142, 8'h00);
    rdc(9'h143, 8'h02);
    $display("frame counters done");
    end_of_test();
  end
endmodule : test_mpp_regs
